// ### src/mq_port_ctrl.sv
// Notes on behaviour
// - Single rate: store one word per write rise with enable, select low, not full.
// - Double rate: qualified rise stores on that rise and the next fall.
// - Write enable and select are sampled on write-clock rises only.
// - Fall word is stored whatever enable shows at the fall.
// - High write select blocks both rise and fall stores.
// - Words are stored in order, independent of reads.
// - Write rate strap is latched while master reset is held.
// - Read rate strap is latched while master reset is held.
// - Single rate: read one word per read rise with enable, select low, not empty.
// - Double rate: qualified read rise also reads on the next fall.
// - Standard mode: enable and select both high, no read that cycle.
// - Empty and almost-empty flags only change on read-clock edges and resets.
// - Standard mode: empty flag drops after last read and blocks reads.
// - Standard mode: empty flag rises two read rises after a write.
// - Read select low drives bus next rise; high floats and blocks reads, except a fall-through load into an empty output register.
// - During reset select is ignored; first rise after reset hands over.
// - Read select does not gate flag updates.
// - Fall-through: first word reaches output register on third read rise.
// - Output enable low drives register contents; high floats the bus.
// - Fall-through mode strap is latched while master reset is held.
// - Master reset clears all pointers and the output register.
`default_nettype none
`include "mq_defs.svh"
module mq_port_ctrl
  import mq_pkg::*;
#(
  parameter int W         = `MQ_DATA_W,
  parameter int DEPTH     = `MQ_DEPTH,
  parameter int AE_OFFSET = `MQ_AE_OFFSET
) (
  input  wire logic         SYS_CLK_I,
  input  wire logic         RSTN_I,
  input  wire logic         MASTER_RESET_N_I,
  input  wire logic [3:0]   QUEUE_RESET_N_I,
  input  wire logic         WRITE_CLK_I,
  input  wire logic         WRITE_ENABLE_N_I,
  input  wire logic         WRITE_PORT_SELECT_N_I,
  input  wire logic         WRITE_DUAL_EDGE_SELECT_I,
  input  wire logic [1:0]   WRITE_QUEUE_SEL_I,
  input  wire logic [W-1:0] WRITE_DATA_I,
  input  wire logic         READ_CLK_I,
  input  wire logic         READ_ENABLE_N_I,
  input  wire logic         READ_PORT_SELECT_N_I,
  input  wire logic         READ_DUAL_EDGE_SELECT_I,
  input  wire logic [1:0]   READ_QUEUE_SEL_I,
  input  wire logic         FALL_THROUGH_SELECT_I,
  input  wire logic         OUTPUT_ENABLE_N_I,
  output logic      [W-1:0] READ_DATA_O,
  output logic              READ_DATA_OE_O,
  output logic      [3:0]   QUEUE_EMPTY_N_O,
  output logic      [3:0]   QUEUE_FULL_N_O,
  output logic      [3:0]   ALMOST_EMPTY_N_O,
  output logic              FALL_THROUGH_MODE_O
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int SW = W + 19;
  localparam logic [SW-1:0] SRST = {5'h00, 1'h0, 2'h3, 1'h0, 2'h0, {W{1'b0}},
                                    1'h0, 2'h3, 1'h0, 2'h0, 1'h0, 1'h1};

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [SW-1:0] s;

  mq_sync #(
    .W       (SW),
    .RST_VAL (SRST)
  ) u_sync (
    .clk_i  (SYS_CLK_I),
    .rstn_i (RSTN_I),
    .d_i    ({MASTER_RESET_N_I, QUEUE_RESET_N_I, WRITE_CLK_I, WRITE_ENABLE_N_I,
              WRITE_PORT_SELECT_N_I, WRITE_DUAL_EDGE_SELECT_I, WRITE_QUEUE_SEL_I,
              WRITE_DATA_I, READ_CLK_I, READ_ENABLE_N_I, READ_PORT_SELECT_N_I,
              READ_DUAL_EDGE_SELECT_I, READ_QUEUE_SEL_I, FALL_THROUGH_SELECT_I,
              OUTPUT_ENABLE_N_I}),
    .q_o    (s)
  );

  wire logic         mrs_n_s = s[SW-1];
  wire logic [3:0]   prs_n_s = s[SW-2 -: 4];
  wire logic         wclk_s  = s[SW-6];
  wire logic         wen_n_s = s[SW-7];
  wire logic         wcs_n_s = s[SW-8];
  wire logic         write_dual_edge_select_s  = s[SW-9];
  wire mq_qsel_t     wq_s    = s[SW-10 -: 2];
  wire logic [W-1:0] wdata_s = s[SW-12 -: W];
  wire logic         rclk_s  = s[7];
  wire logic         ren_n_s = s[6];
  wire logic         rcs_n_s = s[5];
  wire logic         read_dual_edge_select_s  = s[4];
  wire mq_qsel_t     rq_s    = s[3:2];
  wire logic         fts_s   = s[1];
  wire logic         oe_n_s  = s[0];

  // ==========================================================
  // Queue store
  // ==========================================================
  mq_mem_if #(.W(W), .CW(CW)) mi ();

  mq_queue_mem #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_mem (
    .clk_i  (SYS_CLK_I),
    .rstn_i (RSTN_I),
    .mi     (mi.store)
  );

  // ==========================================================
  // State
  // ==========================================================
  logic         wclk_d_reg;
  logic         rclk_d_reg;
  logic         fall_through_mode_reg;
  logic         write_dual_edge_select_reg;
  logic         read_dual_edge_select_reg;
  mq_ph_e       wr_ph_reg;
  mq_ph_e       wr_ph_next;
  mq_ph_e       rd_ph_reg;
  mq_ph_e       rd_ph_next;
  mq_qsel_t     wq_hold_reg;
  mq_qsel_t     rq_hold_reg;
  logic         out_valid_reg;
  logic         out_valid_next;
  logic         rcs_gate_reg;
  logic [W-1:0] out_reg;
  logic         oe_reg;

  // ==========================================================
  // Decode
  // ==========================================================
  logic       mrs_act;
  logic [3:0] clr;
  logic       any_rst;
  logic       w_rise;
  logic       w_fall;
  logic       r_rise;
  logic       r_fall;
  logic [3:0] full_v;
  logic [3:0] nz_v;
  logic [3:0] vis2_v;
  logic [3:0] std_ef_v;
  logic       wr_rise_go;
  logic       wr_fall_go;
  logic       rd_req;
  logic       std_rise_go;
  logic       fall_through_mode_load;
  logic       fall_through_mode_drop;
  logic       rd_arm;
  logic       rd_fall_go;
  logic       rd_rise_go;
  logic       rd_go;
  mq_qsel_t   rd_qe;
  logic       emptied;

  assign mrs_act = !mrs_n_s;
  assign clr     = {4{mrs_act}} | ~prs_n_s;
  assign any_rst = |clr;
  assign w_rise  = wclk_s && !wclk_d_reg;
  assign w_fall  = !wclk_s && wclk_d_reg;
  assign r_rise  = rclk_s && !rclk_d_reg;
  assign r_fall  = !rclk_s && rclk_d_reg;

  for (genvar q = 0; q < 4; q++) begin : g_st
    assign full_v[q] = (mi.cnt[q] == CW'(DEPTH));
    assign nz_v[q]   = (mi.cnt[q] != '0);
  end

  // Write side: enable and select only looked at on a rise
  assign wr_rise_go = w_rise && !wen_n_s && !wcs_n_s && !full_v[wq_s]
                      && !clr[wq_s];
  assign wr_fall_go = w_fall && write_dual_edge_select_reg && (wr_ph_reg == PH_FALL)
                      && !full_v[wq_hold_reg] && !clr[wq_hold_reg];
  assign wr_ph_next = w_rise ? (wr_rise_go && write_dual_edge_select_reg ? PH_FALL : PH_IDLE)
                    : w_fall ? PH_IDLE : wr_ph_reg;

  assign mi.wr_en   = wr_rise_go || wr_fall_go;
  assign mi.wr_q    = wr_rise_go ? wq_s : wq_hold_reg;
  assign mi.wr_data = wdata_s;
  assign mi.clr     = clr;

  // Read side
  assign rd_req      = !ren_n_s && !rcs_n_s;
  assign std_rise_go = !fall_through_mode_reg && r_rise && rd_req
                       && std_ef_v[rq_s] && !clr[rq_s];
  assign fall_through_mode_load   = fall_through_mode_reg && r_rise && vis2_v[rq_s] && nz_v[rq_s]
                       && !clr[rq_s] && (!out_valid_reg || rd_req);
  assign fall_through_mode_drop   = fall_through_mode_reg && r_rise && out_valid_reg && rd_req && !fall_through_mode_load;
  assign rd_arm      = std_rise_go || (fall_through_mode_reg && r_rise && out_valid_reg && rd_req);
  assign rd_fall_go  = r_fall && read_dual_edge_select_reg && (rd_ph_reg == PH_FALL)
                       && nz_v[rq_hold_reg] && !clr[rq_hold_reg];
  assign rd_rise_go  = std_rise_go || fall_through_mode_load;
  assign rd_go       = rd_rise_go || rd_fall_go;
  assign rd_qe       = rd_rise_go ? rq_s : rq_hold_reg;
  assign emptied     = rd_go && (mi.cnt[rd_qe] == CW'(1));
  assign rd_ph_next  = r_rise ? (rd_arm && read_dual_edge_select_reg ? PH_FALL : PH_IDLE)
                     : r_fall ? PH_IDLE : rd_ph_reg;

  assign mi.rd_en = rd_go;
  assign mi.rd_q  = rd_qe;

  assign out_valid_next = clr[rq_s] ? 1'h0
                        : fall_through_mode_load ? 1'h1
                        : fall_through_mode_drop ? 1'h0 : out_valid_reg;

  // ==========================================================
  // Per-queue flags
  // ==========================================================
  for (genvar q = 0; q < 4; q++) begin : g_q
    logic hit;
    logic vis1_reg;
    logic vis1_next;
    logic vis2_reg;
    logic vis2_next;
    logic ef_reg;
    logic ef_next;
    logic ef_pin_next;
    logic full_now;
    assign hit       = emptied && (rd_qe == 2'(q));
    // Write becomes visible to the read side two read rises later
    assign vis1_next = (clr[q] || hit) ? 1'h0 : r_rise ? nz_v[q] : vis1_reg;
    assign vis2_next = (clr[q] || hit) ? 1'h0 : r_rise ? vis1_reg : vis2_reg;
    // Empty flag rises on the second read rise; fall-through loads on the third
    assign ef_next   = (clr[q] || hit) ? 1'h0 : r_rise ? vis1_reg : ef_reg;
    assign ef_pin_next = fall_through_mode_reg ? !((rq_s == 2'(q)) ? out_valid_next : vis2_next)
                                  : ef_next;
    assign full_now  = full_v[q] && !clr[q];
    assign vis2_v[q]   = vis2_reg;
    assign std_ef_v[q] = ef_reg;
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
        vis1_reg            <= 1'h0;
        vis2_reg            <= 1'h0;
        ef_reg              <= 1'h0;
        QUEUE_EMPTY_N_O[q]  <= 1'h0;
        QUEUE_FULL_N_O[q]   <= 1'h1;
        ALMOST_EMPTY_N_O[q] <= 1'h0;
      end else begin
        vis1_reg <= vis1_next;
        vis2_reg <= vis2_next;
        ef_reg   <= ef_next;
        if (clr[q] || r_rise || r_fall) begin
          QUEUE_EMPTY_N_O[q] <= ef_pin_next;
        end
        if (clr[q] || r_rise) begin
          ALMOST_EMPTY_N_O[q] <= !clr[q] && (mi.cnt[q] > CW'(AE_OFFSET));
        end
        if (clr[q] || w_rise) begin
          QUEUE_FULL_N_O[q] <= fall_through_mode_reg ? full_now : !full_now;
        end
      end
    end
  end

  // ==========================================================
  // Configuration straps
  // ==========================================================
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fall_through_mode_reg <= 1'h0;
      write_dual_edge_select_reg <= 1'h0;
      read_dual_edge_select_reg <= 1'h0;
    end else if (mrs_act) begin
      fall_through_mode_reg <= fts_s;
      write_dual_edge_select_reg <= write_dual_edge_select_s;
      read_dual_edge_select_reg <= read_dual_edge_select_s;
    end
  end

  assign FALL_THROUGH_MODE_O = fall_through_mode_reg;

  // ==========================================================
  // Port sequencing
  // ==========================================================
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wclk_d_reg    <= 1'h0;
      rclk_d_reg    <= 1'h0;
      wr_ph_reg     <= PH_IDLE;
      rd_ph_reg     <= PH_IDLE;
      wq_hold_reg   <= '0;
      rq_hold_reg   <= '0;
      out_valid_reg <= 1'h0;
    end else begin
      wclk_d_reg    <= wclk_s;
      rclk_d_reg    <= rclk_s;
      wr_ph_reg     <= any_rst ? PH_IDLE : wr_ph_next;
      rd_ph_reg     <= any_rst ? PH_IDLE : rd_ph_next;
      out_valid_reg <= out_valid_next;
      if (w_rise) begin
        wq_hold_reg <= wq_s;
      end
      if (r_rise) begin
        rq_hold_reg <= rq_s;
      end
    end
  end

  // ==========================================================
  // Output register and bus drive
  // ==========================================================
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      out_reg      <= '0;
      rcs_gate_reg <= 1'h1;
      oe_reg       <= 1'h0;
    end else begin
      if (clr[rq_s]) begin
        out_reg <= '0;
      end else if (rd_go) begin
        out_reg <= mi.rd_data;
      end
      if (any_rst) begin
        rcs_gate_reg <= 1'h1;
      end else if (r_rise) begin
        rcs_gate_reg <= !rcs_n_s;
      end
      oe_reg <= !oe_n_s && rcs_gate_reg;
    end
  end

  assign READ_DATA_O    = out_reg;
  assign READ_DATA_OE_O = oe_reg;
endmodule
`default_nettype wire

// ### src/mq_defs.svh
`ifndef MQ_DEFS_SVH
`define MQ_DEFS_SVH
`define MQ_DATA_W    40
`define MQ_DEPTH     8192
`define MQ_NUM_Q     4
`define MQ_AE_OFFSET 7
`endif

// ### src/mq_pkg.sv
`default_nettype none
package mq_pkg;
  // Second-edge phase of a dual-edge transfer
  typedef enum logic [0:0] {
    PH_IDLE = 1'h0,
    PH_FALL = 1'h1
  } mq_ph_e;
  typedef logic [1:0] mq_qsel_t;
endpackage
`default_nettype wire

// ### src/mq_mem_if.sv
`default_nettype none
interface mq_mem_if #(
  parameter int W  = 40,
  parameter int CW = 14
);
  logic          wr_en;
  logic [1:0]    wr_q;
  logic [W-1:0]  wr_data;
  logic          rd_en;
  logic [1:0]    rd_q;
  logic [W-1:0]  rd_data;
  logic [3:0]    clr;
  logic [CW-1:0] cnt [4];
  modport ctrl  (output wr_en, wr_q, wr_data, rd_en, rd_q, clr, input rd_data, cnt);
  modport store (input wr_en, wr_q, wr_data, rd_en, rd_q, clr, output rd_data, cnt);
endinterface
`default_nettype wire

// ### src/mq_sync.sv
`default_nettype none
module mq_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= RST_VAL;
      q_o      <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### src/mq_queue_mem.sv
`default_nettype none
module mq_queue_mem #(
  parameter int W     = 40,
  parameter int DEPTH = 8192
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  mq_mem_if.store   mi
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  ram [0:4*DEPTH-1];
  logic [AW-1:0] wp_v [4];
  logic [AW-1:0] rp_v [4];

  assign mi.rd_data = ram[{mi.rd_q, rp_v[mi.rd_q]}];

  // Sequential store, untouched by the read side
  always_ff @(posedge clk_i) begin
    if (mi.wr_en) begin
      ram[{mi.wr_q, wp_v[mi.wr_q]}] <= mi.wr_data;
    end
  end

  for (genvar q = 0; q < 4; q++) begin : g_q
    logic          do_w;
    logic          do_r;
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    assign do_w     = mi.wr_en && (mi.wr_q == 2'(q));
    assign do_r     = mi.rd_en && (mi.rd_q == 2'(q));
    assign cnt_next = CW'(cnt_reg + CW'(do_w) - CW'(do_r));
    assign wp_v[q]  = wp_reg;
    assign rp_v[q]  = rp_reg;
    assign mi.cnt[q] = cnt_reg;
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        wp_reg  <= '0;
        rp_reg  <= '0;
        cnt_reg <= '0;
      end else if (mi.clr[q]) begin
        wp_reg  <= '0;
        rp_reg  <= '0;
        cnt_reg <= '0;
      end else begin
        wp_reg  <= AW'(wp_reg + AW'(do_w));
        rp_reg  <= AW'(rp_reg + AW'(do_r));
        cnt_reg <= cnt_next;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/mq_port_ctrl_sva.sv
`default_nettype none
module mq_port_ctrl_sva #(
  parameter int W = 40
) (
  input wire logic         SYS_CLK_I,
  input wire logic         RSTN_I,
  input wire logic         MASTER_RESET_N_I,
  input wire logic [3:0]   QUEUE_RESET_N_I,
  input wire logic         READ_CLK_I,
  input wire logic         READ_PORT_SELECT_N_I,
  input wire logic         FALL_THROUGH_SELECT_I,
  input wire logic         OUTPUT_ENABLE_N_I,
  input wire logic [W-1:0] READ_DATA_O,
  input wire logic         READ_DATA_OE_O,
  input wire logic [3:0]   QUEUE_EMPTY_N_O,
  input wire logic [3:0]   ALMOST_EMPTY_N_O,
  input wire logic         FALL_THROUGH_MODE_O
);
  // ==========
  // Cycles since the last read clock rise
  logic       rclk_d_reg;
  logic [3:0] since_reg;
  logic [3:0] since_next;
  assign since_next = (READ_CLK_I && !rclk_d_reg) ? 4'h0 : ((since_reg == 4'hF) ? 4'hF : since_reg + 4'h1);
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rclk_d_reg <= 1'b0;
      since_reg  <= 4'hF;
    end else begin
      rclk_d_reg <= READ_CLK_I;
      since_reg  <= since_next;
    end
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence mr_held;
    !MASTER_RESET_N_I [*6];
  endsequence
  sequence run_quiet;
    (MASTER_RESET_N_I && &QUEUE_RESET_N_I) [*6];
  endsequence
  mr_clear_a: assert property (mr_held |-> READ_DATA_O == '0 && ALMOST_EMPTY_N_O == 4'h0)
    else $error("reset did not clear output or almost empty");
  mode_latch_a: assert property ((!MASTER_RESET_N_I && $stable(FALL_THROUGH_SELECT_I)) [*6]
    |-> FALL_THROUGH_MODE_O == FALL_THROUGH_SELECT_I) else $error("mode not latched");
  mode_hold_a: assert property (MASTER_RESET_N_I [*8] |-> $stable(FALL_THROUGH_MODE_O))
    else $error("mode changed outside reset");
  oe_pin_a: assert property (OUTPUT_ENABLE_N_I [*4] |-> !READ_DATA_OE_O)
    else $error("bus driven with output enable high");
  oe_reset_a: assert property ((!MASTER_RESET_N_I && !OUTPUT_ENABLE_N_I) [*6] |-> READ_DATA_OE_O)
    else $error("bus not driven during reset");
  rcs_off_a: assert property (run_quiet ##0 ($rose(READ_CLK_I) && READ_PORT_SELECT_N_I)
    |-> ##[2:6] !READ_DATA_OE_O) else $error("bus not released by select");
  rcs_on_a: assert property ((MASTER_RESET_N_I && &QUEUE_RESET_N_I && !OUTPUT_ENABLE_N_I) [*6]
    ##0 ($rose(READ_CLK_I) && !READ_PORT_SELECT_N_I) |-> ##[2:6] READ_DATA_OE_O) else $error("bus not driven");
  flag_stop_a: assert property (($stable(READ_CLK_I) && MASTER_RESET_N_I && &QUEUE_RESET_N_I) [*8]
    |-> $stable(QUEUE_EMPTY_N_O) && $stable(ALMOST_EMPTY_N_O)) else $error("flags moved with read clock idle");
  empty_rise_a: assert property (run_quiet ##0 (!FALL_THROUGH_MODE_O
    && |(QUEUE_EMPTY_N_O & ~$past(QUEUE_EMPTY_N_O))) |-> since_reg <= 4'h7) else $error("empty flag rose off clock");
endmodule
bind mq_port_ctrl mq_port_ctrl_sva #(.W(W)) u_sva (.*);
`default_nettype wire

// ### testbench/mq_far_model.sv
`default_nettype none
module mq_far_model (
  input  wire logic  clk_i,
  output logic        wclk_o,
  output logic        wen_n_o,
  output logic        wcs_n_o,
  output logic [39:0] wdata_o,
  output logic        rclk_o,
  output logic        ren_n_o,
  output logic        rcs_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // Producer and consumer, clocks idle low between frames
  initial begin
    wclk_o = 1'b0;
    rclk_o = 1'b0;
    wen_n_o = 1'b1;
    wcs_n_o = 1'b1;
    wdata_o = 40'h0;
    ren_n_o = 1'b1;
    rcs_n_o = 1'b0;
  end
  task automatic wr(input logic [39:0] d0, input logic [39:0] d1, input logic en_n, input logic cs_n);
    @(posedge clk_i);
    #1 wen_n_o = en_n;
    wcs_n_o = cs_n;
    wdata_o = d0;
    #2 wclk_o = 1'b1;
    #20 wen_n_o = 1'b1;
    wdata_o = d1;
    #4 wclk_o = 1'b0;
    #24 wdata_o = ~d1;
    wcs_n_o = 1'b1;
  endtask
  task automatic rd(input logic en_n, input logic cs_n);
    @(posedge clk_i);
    #1 ren_n_o = en_n;
    rcs_n_o = cs_n;
    #2 rclk_o = 1'b1;
    #24 rclk_o = 1'b0;
    #24 ren_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### testbench/test_multi_queue_fifo_port_control.sv
`default_nettype none
module test_multi_queue_fifo_port_control
  import mq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rstn, mrst_n, write_dual_edge_select, fall_through_mode, oe_n, oe, mode;
  logic        wclk, wen_n, wcs_n, rclk, ren_n, rcs_n;
  mq_qsel_t    wsel, rsel;
  logic [39:0] wdata, rdata, prev, a, b;
  logic [39:0] d[3];
  logic [39:0] exp_q[$];
  logic [3:0]  empty_n, full_n, ae_n;
  int          failures, checked, cyc;
  integer      seed;
  mq_far_model far (.clk_i(clk), .wclk_o(wclk), .wen_n_o(wen_n), .wcs_n_o(wcs_n), .wdata_o(wdata),
    .rclk_o(rclk), .ren_n_o(ren_n), .rcs_n_o(rcs_n));
  mq_port_ctrl #(.DEPTH(16)) dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .MASTER_RESET_N_I(mrst_n),
    .QUEUE_RESET_N_I(4'hF), .WRITE_CLK_I(wclk), .WRITE_ENABLE_N_I(wen_n), .WRITE_PORT_SELECT_N_I(wcs_n),
    .WRITE_DUAL_EDGE_SELECT_I(write_dual_edge_select), .WRITE_QUEUE_SEL_I(wsel), .WRITE_DATA_I(wdata), .READ_CLK_I(rclk),
    .READ_ENABLE_N_I(ren_n), .READ_PORT_SELECT_N_I(rcs_n), .READ_DUAL_EDGE_SELECT_I(1'b0),
    .READ_QUEUE_SEL_I(rsel), .FALL_THROUGH_SELECT_I(fall_through_mode), .OUTPUT_ENABLE_N_I(oe_n), .READ_DATA_O(rdata),
    .READ_DATA_OE_O(oe), .QUEUE_EMPTY_N_O(empty_n), .QUEUE_FULL_N_O(full_n), .ALMOST_EMPTY_N_O(ae_n),
    .FALL_THROUGH_MODE_O(mode));
  // ==========
  // Checking and run control
  task automatic cmp_flag(input string nm, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_data(input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH read data expected %h seen %h", e, g);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [39:0] rnd();
    logic [63:0] t;
    t = {$random(seed), $random(seed)};
    return t[39:0] | 40'h1;
  endfunction
  task automatic reset_dev(input logic w2, input logic ft);
    @(posedge clk);
    #1 mrst_n = 1'b0;
    write_dual_edge_select = w2;
    fall_through_mode = ft;
    repeat (8) @(posedge clk);
    #1 mrst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end
  // Each change of the output register consumes the oldest note
  always @(negedge clk) begin
    if (rstn && mrst_n && rdata !== prev) begin
      if (exp_q.size() > 0) begin
        cmp_data(exp_q.pop_front(), rdata);
      end else begin
        cmp_data(prev, rdata);
      end
    end
    prev = rdata;
  end
  // ==========
  // Scenarios
  initial begin
    seed = 76;
    failures = 0;
    checked = 0;
    cyc = 0;
    prev = '0;
    rstn = 1'b0;
    mrst_n = 1'b0;
    write_dual_edge_select = 1'b0;
    fall_through_mode = 1'b0;
    oe_n = 1'b0;
    wsel = 2'h2;
    rsel = 2'h2;
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    reset_dev(1'b0, 1'b0);
    cmp_flag("empty", 4'h0, empty_n);
    cmp_flag("full", 4'hF, full_n);
    cmp_flag("almost empty", 4'h0, ae_n);
    cmp_flag("mode", 4'h0, {3'h0, mode});
    foreach (d[i]) d[i] = rnd();
    far.wr(d[0], rnd(), 1'b0, 1'b0);
    far.rd(1'b1, 1'b1);
    cmp_flag("empty", 4'h0, empty_n);
    far.rd(1'b1, 1'b1);
    cmp_flag("empty", 4'h4, empty_n);
    cmp_flag("bus drive", 4'h0, {3'h0, oe});
    far.wr(rnd(), rnd(), 1'b0, 1'b1);
    far.wr(rnd(), rnd(), 1'b1, 1'b0);
    far.wr(d[1], rnd(), 1'b0, 1'b0);
    far.wr(d[2], rnd(), 1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(d[i]);
      far.rd(1'b0, 1'b0);
    end
    far.rd(1'b1, 1'b1);
    far.rd(1'b0, 1'b0);
    cmp_flag("empty", 4'h0, empty_n);
    cmp_flag("bus drive", 4'h1, {3'h0, oe});
    oe_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    cmp_flag("bus drive", 4'h0, {3'h0, oe});
    oe_n = 1'b0;
    $display("standard single rate test done");
    wsel = 2'h1;
    rsel = 2'h1;
    reset_dev(1'b1, 1'b1);
    cmp_flag("mode", 4'h1, {3'h0, mode});
    cmp_flag("output ready", 4'hF, empty_n);
    a = rnd();
    b = rnd();
    far.wr(a, b, 1'b0, 1'b0);
    exp_q.push_back(a);
    repeat (3) far.rd(1'b1, 1'b1);
    cmp_flag("bus drive", 4'h0, {3'h0, oe});
    exp_q.push_back(b);
    far.rd(1'b0, 1'b0);
    cmp_flag("bus drive", 4'h1, {3'h0, oe});
    repeat (8) @(posedge clk);
    cmp_flag("pending reads", 4'h0, 4'(exp_q.size()));
    $display("fall through double rate test done");
    stop_test();
  end
endmodule
`default_nettype wire
